// >>> pkg/hpm_pkg.sv
// Shared constants and types of the halt power mode controller.
// Assumes one CPU clock; every count is in cycles of that clock.
`default_nettype none
package hpm_pkg;
    // Halt opcode and forced interrupt level on entry
    localparam logic [7:0] HPM_HALT_OPCODE   = 8'h8E;
    localparam logic [1:0] HPM_CC_PRIO_HALT  = 2'h2;
    localparam logic [1:0] HPM_CC_PRIO_RST   = 2'h3;
    // Stabilization delays in CPU cycles, and clocks per CPU cycle
    localparam int         HPM_STAB_SHORT_TCPU = 256;
    localparam int         HPM_STAB_LONG_TCPU  = 4096;
    localparam int         HPM_CLK_PER_TCPU    = 1;
    localparam int         HPM_STAB_SHORT_CYC  =
        HPM_STAB_SHORT_TCPU * HPM_CLK_PER_TCPU;
    localparam int         HPM_STAB_LONG_CYC   =
        HPM_STAB_LONG_TCPU * HPM_CLK_PER_TCPU;
    // Register bus
    localparam int         HPM_ADDR_W      = 8;
    localparam int         HPM_DATA_W      = 32;
    localparam logic [7:0] HPM_OFS_CTRL    = 8'h00;
    localparam logic [7:0] HPM_OFS_STATUS  = 8'h04;
    localparam logic [7:0] HPM_OFS_IRQ_ST  = 8'h08;
    localparam logic [7:0] HPM_OFS_IRQ_CLR = 8'h0C;
    localparam logic [7:0] HPM_OFS_IRQ_EN  = 8'h10;
    // Field positions
    localparam int         HPM_CTRL_TB_EN  = 0;
    localparam int         HPM_ST_BUSY     = 2;
    localparam int         HPM_ST_GUARD    = 3;
    localparam int         HPM_ST_LONG     = 4;
    localparam int         HPM_EV_HALT     = 0;
    localparam int         HPM_EV_WAKE_TB  = 1;
    localparam int         HPM_EV_WAKE_EXT = 2;
    localparam int         HPM_EV_WDG      = 3;
    localparam int         HPM_EV_N        = 4;
    // Reset values
    localparam logic       HPM_TB_EN_RST   = 1'b0;
    localparam logic [3:0] HPM_EV_RST      = 4'h0;
    // Power states
    typedef enum logic [1:0] {
        HPM_RUN      = 2'b00,
        HPM_ACT_HALT = 2'b01,
        HPM_FULL_HALT= 2'b10,
        HPM_STAB     = 2'b11
    } hpm_state_t;
endpackage
`default_nettype wire

// >>> rtl/hpm_ctrl.sv
// Halt power mode controller: halt decode, clock gating, wake, delays.
// Assumes opcode_valid marks an executed opcode, CPU owns the CC stack.
//
// Behaviour
// - Halt enters full halt if timebase enable is 0, active-halt if 1.
// - Halt instruction is decoded from opcode 0x8E.
// - Active-halt is left only by timebase interrupt or reset.
// - Timebase wake from active-halt services it at once, no delay.
// - Reset wake from active-halt waits the stabilization delay first.
// - Entering halt forces CC priority to 10b; pending wake exits at once.
// - Active-halt keeps only oscillator and timebase clocked.
// - Active-halt entry with watchdog active gives no watchdog reset.
// - Clearing timebase enable during the guard delay drops to the stabilization state.
// - Full halt stops the oscillator, CPU and all peripherals.
// - Full halt exit restarts oscillator, waits delay, then services.
// - Only halt-capable interrupts wake from full halt.
// - Watchdog-in-halt option decides if halt gives a watchdog reset.
// - Wake service pushes CC, loads level, restores on pop.
`default_nettype none
module hpm_ctrl
    import hpm_pkg::*;
#(
    parameter int          N_EXT    = 4,
    parameter logic [31:0] HALT_MSK = 32'h0000000F
) (
    input  wire logic                  ref_clk,
    input  wire logic                  resetn,
    input  wire logic [HPM_ADDR_W-1:0] reg_addr,
    input  wire logic [HPM_DATA_W-1:0] reg_wdata,
    input  wire logic                  reg_wr,
    input  wire logic                  reg_rd,
    output logic      [HPM_DATA_W-1:0] reg_rdata,
    input  wire logic                  opcode_valid,
    input  wire logic [7:0]            opcode,
    input  wire logic                  timebase_irq,
    input  wire logic [N_EXT-1:0]      ext_irq,
    input  wire logic                  watchdog_active,
    input  wire logic                  watchdog_in_halt_option,
    input  wire logic                  stab_long_option,
    input  wire logic [1:0]            irq_sw_level,
    input  wire logic                  cc_pop,
    input  wire logic [1:0]            cc_popped_prio,
    output logic                       osc_en,
    output logic                       cpu_clk_en,
    output logic                       periph_clk_en,
    output logic                       timebase_clk_en,
    output logic [1:0]                 cc_prio,
    output logic                       cc_push,
    output logic                       irq_service,
    output logic                       irq_from_ext,
    output logic                       reset_fetch,
    output logic                       watchdog_reset_req,
    output logic                       irq
);
    // Reset release synchronizer
    logic rst_meta_r;
    logic rst_sync_r;
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            rst_meta_r <= 1'b0;
            rst_sync_r <= 1'b0;
        end else begin
            rst_meta_r <= 1'b1;
            rst_sync_r <= rst_meta_r;
        end
    end
    wire rst_n = rst_sync_r;

    // State and control registers
    hpm_state_t state_r;
    hpm_state_t state_nxt;
    logic       tb_en_r;
    logic       boot_r;
    logic       guard_r;
    logic       pend_irq_r;
    logic       pend_ext_r;
    logic [HPM_EV_N-1:0] ev_st_r;
    logic [HPM_EV_N-1:0] ev_en_r;

    // Wake sources and stabilization timer
    logic tb_wake;
    logic ext_wake;
    logic tmr_busy;
    logic tmr_done;

    hpm_wake_detect #(
        .N_EXT    (N_EXT),
        .HALT_MSK (HALT_MSK)
    ) u_wake (
        .timebase_irq (timebase_irq),
        .ext_irq      (ext_irq),
        .tb_wake      (tb_wake),
        .ext_wake     (ext_wake)
    );

    // Halt decode and watchdog decision
    wire halt_exec  = opcode_valid && (opcode == HPM_HALT_OPCODE)
                      && (state_r == HPM_RUN);
    wire wdg_block  = !tb_en_r && watchdog_active
                      && !watchdog_in_halt_option;
    wire halt_enter = halt_exec && !wdg_block;
    wire act_wake   = (state_r == HPM_ACT_HALT) && tb_wake;
    wire full_wake  = (state_r == HPM_FULL_HALT) && ext_wake;
    wire guard_drop = guard_r && !tmr_done && !tb_en_r
                      && (state_r == HPM_RUN);
    wire stab_end   = (state_r == HPM_STAB) && tmr_done;
    wire tmr_start  = boot_r || full_wake || act_wake;
    wire svc_now    = act_wake || (stab_end && pend_irq_r);

    hpm_stab_timer #(
        .SHORT_CYC (HPM_STAB_SHORT_CYC),
        .LONG_CYC  (HPM_STAB_LONG_CYC)
    ) u_tmr (
        .ref_clk  (ref_clk),
        .rst_n    (rst_n),
        .start    (tmr_start),
        .long_sel (stab_long_option),
        .busy     (tmr_busy),
        .done     (tmr_done)
    );

    // Next power state
    always_comb begin
        state_nxt = state_r;
        unique case (state_r)
            HPM_RUN: begin
                if (halt_enter)
                    state_nxt = tb_en_r ? HPM_ACT_HALT
                                        : HPM_FULL_HALT;
                else if (guard_drop)
                    state_nxt = HPM_STAB;
            end
            HPM_ACT_HALT: begin
                if (tb_wake) state_nxt = HPM_RUN;
            end
            HPM_FULL_HALT: begin
                if (ext_wake) state_nxt = HPM_STAB;
            end
            HPM_STAB: begin
                if (tmr_done) state_nxt = HPM_RUN;
            end
        endcase
    end

    // Clock enables follow the next state so they align with state_r
    wire nx_run  = (state_nxt == HPM_RUN);
    wire nx_act  = (state_nxt == HPM_ACT_HALT);
    wire nx_stab = (state_nxt == HPM_STAB);
    wire osc_nxt = !(state_nxt == HPM_FULL_HALT);

    // Power state, clock gating and wake bookkeeping
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            state_r         <= HPM_STAB;
            boot_r          <= 1'b1;
            osc_en          <= 1'b1;
            cpu_clk_en      <= 1'b0;
            periph_clk_en   <= 1'b0;
            timebase_clk_en <= 1'b0;
        end else begin
            state_r         <= state_nxt;
            boot_r          <= 1'b0;
            osc_en          <= osc_nxt;
            cpu_clk_en      <= nx_run;
            periph_clk_en   <= nx_run;
            timebase_clk_en <= nx_run || nx_act || nx_stab;
        end
    end

    // Guard window after a timebase wake, and pending service kind
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            guard_r    <= 1'b0;
            pend_irq_r <= 1'b0;
            pend_ext_r <= 1'b0;
        end else begin
            if (act_wake)              guard_r <= 1'b1;
            else if (tmr_done || full_wake) guard_r <= 1'b0;
            if (full_wake) begin
                pend_irq_r <= 1'b1;
                pend_ext_r <= 1'b1;
            end else if (stab_end) begin
                pend_irq_r <= 1'b0;
                pend_ext_r <= 1'b0;
            end
        end
    end

    // CC priority: forced on entry, loaded on service, restored on pop
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            cc_prio      <= HPM_CC_PRIO_RST;
            cc_push      <= 1'b0;
            irq_service  <= 1'b0;
            irq_from_ext <= 1'b0;
        end else begin
            cc_push     <= svc_now;
            irq_service <= svc_now;
            if (svc_now)
                irq_from_ext <= pend_ext_r && !act_wake;
            if (halt_enter)   cc_prio <= HPM_CC_PRIO_HALT;
            else if (svc_now) cc_prio <= irq_sw_level;
            else if (cc_pop)  cc_prio <= cc_popped_prio;
        end
    end

    // Reset vector fetch after reset stabilization, watchdog reset
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            reset_fetch        <= 1'b0;
            watchdog_reset_req <= 1'b0;
        end else begin
            reset_fetch        <= stab_end && !pend_irq_r
                                  && !guard_r;
            watchdog_reset_req <= halt_exec && wdg_block;
        end
    end

    // Register decode
    wire wr_ctrl = reg_wr && (reg_addr == HPM_OFS_CTRL);
    wire wr_clr  = reg_wr && (reg_addr == HPM_OFS_IRQ_CLR);
    wire wr_en   = reg_wr && (reg_addr == HPM_OFS_IRQ_EN);
    wire [HPM_EV_N-1:0] ev_set = {halt_exec && wdg_block, full_wake,
                                  act_wake, halt_enter};
    wire [HPM_EV_N-1:0] ev_clr = wr_clr ? reg_wdata[HPM_EV_N-1:0] : '0;
    wire [HPM_EV_N-1:0] ev_nxt = (ev_st_r & ~ev_clr) | ev_set;
    wire [HPM_DATA_W-1:0] st_word = {{(HPM_DATA_W-5){1'b0}},
                                     stab_long_option, guard_r,
                                     tmr_busy, state_r};
    wire [HPM_DATA_W-1:0] rd_mux =
        (reg_addr == HPM_OFS_CTRL)   ? {{(HPM_DATA_W-1){1'b0}}, tb_en_r} :
        (reg_addr == HPM_OFS_STATUS) ? st_word :
        (reg_addr == HPM_OFS_IRQ_ST) ?
            {{(HPM_DATA_W-HPM_EV_N){1'b0}}, ev_st_r} :
        (reg_addr == HPM_OFS_IRQ_EN) ?
            {{(HPM_DATA_W-HPM_EV_N){1'b0}}, ev_en_r} : '0;

    // Software registers, event flags and interrupt line
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            tb_en_r   <= HPM_TB_EN_RST;
            ev_st_r   <= HPM_EV_RST;
            ev_en_r   <= HPM_EV_RST;
            reg_rdata <= '0;
            irq       <= 1'b0;
        end else begin
            if (wr_ctrl) tb_en_r <= reg_wdata[HPM_CTRL_TB_EN];
            if (wr_en)   ev_en_r <= reg_wdata[HPM_EV_N-1:0];
            ev_st_r   <= ev_nxt;
            reg_rdata <= reg_rd ? rd_mux : '0;
            irq       <= |(ev_nxt & (wr_en ? reg_wdata[HPM_EV_N-1:0]
                                           : ev_en_r));
        end
    end

    // Checks
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rst_n);

    property p_enter_act;
        halt_enter && tb_en_r |=> state_r == HPM_ACT_HALT;
    endproperty
    a_enter_act: assert property (p_enter_act)
        else $error("halt with enable set did not enter active-halt");

    property p_enter_full;
        opcode_valid && opcode == 8'h8E && state_r == HPM_RUN
        && !tb_en_r && !wdg_block |=> state_r == HPM_FULL_HALT;
    endproperty
    a_enter_full: assert property (p_enter_full)
        else $error("halt opcode did not enter full halt");

    property p_act_hold;
        state_r == HPM_ACT_HALT && !timebase_irq |=> state_r == HPM_ACT_HALT;
    endproperty
    a_act_hold: assert property (p_act_hold)
        else $error("active-halt left without timebase interrupt");

    property p_act_wake;
        state_r == HPM_ACT_HALT && timebase_irq
        |=> state_r == HPM_RUN && irq_service && cpu_clk_en;
    endproperty
    a_act_wake: assert property (p_act_wake)
        else $error("timebase wake did not service at once");

    property p_prio_forced;
        halt_enter |=> cc_prio == 2'h2;
    endproperty
    a_prio_forced: assert property (p_prio_forced)
        else $error("CC priority not forced on halt entry");

    property p_act_clocks;
        state_r == HPM_ACT_HALT |-> osc_en && timebase_clk_en
                                    && !cpu_clk_en && !periph_clk_en;
    endproperty
    a_act_clocks: assert property (p_act_clocks)
        else $error("wrong clocks in active-halt");

    property p_no_wdg_act;
        halt_exec && tb_en_r |=> !watchdog_reset_req;
    endproperty
    a_no_wdg_act: assert property (p_no_wdg_act)
        else $error("watchdog reset on active-halt entry");

    property p_wdg_opt;
        halt_exec && !tb_en_r && watchdog_active && !watchdog_in_halt_option
        |=> watchdog_reset_req && state_r == HPM_RUN;
    endproperty
    a_wdg_opt: assert property (p_wdg_opt)
        else $error("watchdog option not honoured on halt");

    property p_guard_drop;
        guard_r && !tmr_done && !tb_en_r && state_r == HPM_RUN
        |=> state_r == HPM_STAB;
    endproperty
    a_guard_drop: assert property (p_guard_drop)
        else $error("guard drop did not stop the CPU");

    property p_full_clocks;
        state_r == HPM_FULL_HALT |-> !osc_en && !cpu_clk_en
                                     && !periph_clk_en && !timebase_clk_en;
    endproperty
    a_full_clocks: assert property (p_full_clocks)
        else $error("clock running in full halt");

    property p_full_exit;
        state_r == HPM_FULL_HALT && ext_wake |=> osc_en && state_r == HPM_STAB;
    endproperty
    a_full_exit: assert property (p_full_exit)
        else $error("no oscillator on wake");

    // Cycles since the last full-halt wake
    logic [12:0] age_r;
    always_ff @(posedge ref_clk) age_r <= full_wake ? '0 : age_r + 13'h1;

    property p_full_len;
        stab_end && pend_ext_r |-> age_r == 13'(stab_long_option ?
            HPM_STAB_LONG_CYC - 1 : HPM_STAB_SHORT_CYC - 1) ##1 irq_service;
    endproperty
    a_full_len: assert property (p_full_len)
        else $error("wake delay wrong");

    property p_push;
        irq_service |-> cc_push;
    endproperty
    a_push: assert property (p_push)
        else $error("service without CC push");

    c_act_cycle: cover property (state_r == HPM_ACT_HALT ##1
                                 state_r == HPM_RUN);
    c_full_cycle: cover property (state_r == HPM_FULL_HALT ##1
                                  state_r == HPM_STAB);
    c_reset_fetch: cover property (reset_fetch);
    c_guard: cover property (guard_drop);
endmodule
`default_nettype wire

// >>> rtl/hpm_stab_timer.sv
// Oscillator stabilization timer: 256 or 4096 cycle countdown.
// Assumes start is a one-cycle pulse; a start while busy reloads.
`default_nettype none
module hpm_stab_timer
    import hpm_pkg::*;
#(
    parameter int SHORT_CYC = HPM_STAB_SHORT_CYC,
    parameter int LONG_CYC  = HPM_STAB_LONG_CYC
) (
    input  wire logic ref_clk,
    input  wire logic rst_n,
    input  wire logic start,
    input  wire logic long_sel,
    output logic      busy,
    output logic      done
);
    localparam int CW = $clog2(LONG_CYC + 1);

    if (SHORT_CYC < 1 || LONG_CYC < SHORT_CYC)
        $error("hpm_stab_timer: bad delay lengths");

    logic [CW-1:0] cnt_r;
    logic [CW-1:0] cnt_nxt;
    wire  [CW-1:0] len = long_sel ? CW'(LONG_CYC) : CW'(SHORT_CYC);

    // Load on start, else count down to zero
    assign cnt_nxt = start ? len : (busy ? cnt_r - CW'(1) : cnt_r);
    assign busy    = (cnt_r != '0);
    assign done    = (cnt_r == CW'(1));

    // Down counter
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) cnt_r <= '0;
        else        cnt_r <= cnt_nxt;
    end
endmodule
`default_nettype wire

// >>> rtl/hpm_wake_detect.sv
// Wake source qualification for both halt states.
// Pure gating with no storage, so it works while the oscillator is off.
`default_nettype none
module hpm_wake_detect
    import hpm_pkg::*;
#(
    parameter int          N_EXT    = 4,
    parameter logic [31:0] HALT_MSK = 32'h0000000F
) (
    input  wire logic             timebase_irq,
    input  wire logic [N_EXT-1:0] ext_irq,
    output logic                  tb_wake,
    output logic                  ext_wake
);
    if (N_EXT < 1 || N_EXT > 32)
        $error("hpm_wake_detect: N_EXT must be 1 to 32");

    wire [N_EXT-1:0] qual;

    // Only lines marked halt-capable may wake full halt
    genvar gi;
    generate
        for (gi = 0; gi < N_EXT; gi++) begin : g_line
            assign qual[gi] = ext_irq[gi] & HALT_MSK[gi];
        end
    endgenerate

    // Combinational wake paths, no clock needed
    assign tb_wake  = timebase_irq;
    assign ext_wake = |qual;
endmodule
`default_nettype wire

// >>> testbench/hpm_cpu_model.sv
// Far-side model: timebase interrupt source and the CPU stack for the CC.
// Assumes the block's clock enables and service pulse come from flops.
`default_nettype none
module hpm_cpu_model #(
    parameter int PERIOD  = 20,
    parameter int RET_DLY = 6
) (
    input  wire logic       ref_clk,
    input  wire logic       resetn,
    input  wire logic       tb_arm,
    input  wire logic       timebase_clk_en,
    input  wire logic       irq_service,
    input  wire logic [1:0] cc_prio,
    output logic            timebase_irq,
    output logic            cc_pop,
    output logic [1:0]      cc_popped_prio
);
    timeunit 1ns;
    timeprecision 1ps;
    int         tb_cnt;
    int         ret_cnt;
    logic [1:0] prio_r;
    logic [1:0] stack_r;
    // Timebase counts only while clocked; the service pulse clears it
    always @(posedge ref_clk or negedge resetn) begin
        if (!resetn || !tb_arm) begin
            tb_cnt <= 0;
            timebase_irq <= 1'b0;
        end else if (irq_service) begin
            tb_cnt <= 0;
            timebase_irq <= 1'b0;
        end else if (timebase_clk_en && !timebase_irq) begin
            tb_cnt <= tb_cnt + 1;
            timebase_irq <= (tb_cnt == PERIOD - 1);
        end
    end
    // Push the level held before service, pop it back after the routine
    always @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            ret_cnt <= 0;
            cc_pop <= 1'b0;
            prio_r <= 2'h3;
            stack_r <= 2'h3;
            cc_popped_prio <= 2'h0;
        end else begin
            cc_pop <= (ret_cnt == 1);
            cc_popped_prio <= (ret_cnt == 1) ? stack_r : ~stack_r;
            if (ret_cnt > 0) ret_cnt <= ret_cnt - 1;
            if (irq_service) begin
                stack_r <= prio_r;
                ret_cnt <= RET_DLY;
            end else begin
                prio_r <= cc_prio;
            end
        end
    end
endmodule
`default_nettype wire

// >>> testbench/hpm_ctrl_tb_top.sv
// Self-checking bench of the halt power mode controller.
// Assumes one 125 MHz clock; far side given by hpm_cpu_model.
`default_nettype none
module hpm_ctrl_tb_top
    import hpm_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic        ref_clk, resetn, reg_wr, reg_rd, opcode_valid;
    logic [7:0]  reg_addr, opcode;
    logic [31:0] reg_wdata, reg_rdata, rv;
    logic [3:0]  ext_irq;
    logic        watchdog_active, watchdog_in_halt_option;
    logic        stab_long_option, cc_pop, timebase_irq, tb_arm;
    logic [1:0]  irq_sw_level, cc_popped_prio, cc_prio, lvl;
    logic        osc_en, cpu_clk_en, periph_clk_en, timebase_clk_en;
    logic        cc_push, irq_service, irq_from_ext, reset_fetch;
    logic        watchdog_reset_req, irq;
    int          n_mismatch = 0;
    int          total_checks = 0;
    int          cycles = 0;
    int          n;
    wire  [3:0]  clks = {osc_en, cpu_clk_en, periph_clk_en, timebase_clk_en};

    hpm_ctrl #(.N_EXT(4), .HALT_MSK(32'h00000007)) uut (
        .ref_clk(ref_clk), .resetn(resetn), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_rdata(reg_rdata), .opcode_valid(opcode_valid),
        .opcode(opcode), .timebase_irq(timebase_irq), .ext_irq(ext_irq),
        .watchdog_active(watchdog_active),
        .watchdog_in_halt_option(watchdog_in_halt_option),
        .stab_long_option(stab_long_option), .irq_sw_level(irq_sw_level),
        .cc_pop(cc_pop), .cc_popped_prio(cc_popped_prio), .osc_en(osc_en),
        .cpu_clk_en(cpu_clk_en), .periph_clk_en(periph_clk_en),
        .timebase_clk_en(timebase_clk_en), .cc_prio(cc_prio),
        .cc_push(cc_push), .irq_service(irq_service),
        .irq_from_ext(irq_from_ext), .reset_fetch(reset_fetch),
        .watchdog_reset_req(watchdog_reset_req), .irq(irq));
    hpm_cpu_model model (
        .ref_clk(ref_clk), .resetn(resetn), .tb_arm(tb_arm),
        .timebase_clk_en(timebase_clk_en), .irq_service(irq_service),
        .cc_prio(cc_prio), .timebase_irq(timebase_irq), .cc_pop(cc_pop),
        .cc_popped_prio(cc_popped_prio));

    // Free-running clock
    initial begin
        ref_clk = 1'b0;
        forever #4 ref_clk = ~ref_clk;
    end
    task automatic wrap_up();
        $display("checks %0d mismatches %0d", total_checks, n_mismatch);
        if (n_mismatch == 0 && total_checks > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask
    task automatic chk(input string nm, input logic [31:0] seen, exp);
        total_checks++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("[FAIL] %s expected %0h seen %0h", nm, exp, seen);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge ref_clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge ref_clk);
        reg_wr <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, output logic [31:0] d);
        @(posedge ref_clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge ref_clk);
        reg_rd <= 1'b0;
        @(negedge ref_clk);
        d = reg_rdata;
    endtask
    // Issue one opcode, then look at the cycle after it was taken
    task automatic exec(input logic [7:0] op);
        @(posedge ref_clk);
        opcode <= op;
        opcode_valid <= 1'b1;
        @(posedge ref_clk);
        opcode_valid <= 1'b0;
        @(negedge ref_clk);
    endtask
    // Bounded wait on one output; n counts cycles
    task automatic wait_sig(input int sel, input int lim);
        logic s;
        n = 0;
        s = 1'b0;
        while (s !== 1'b1 && n < lim) begin
            @(negedge ref_clk);
            n++;
            case (sel)
                0: s = irq_service;
                1: s = reset_fetch;
                2: s = cpu_clk_en;
                default: s = timebase_irq;
            endcase
        end
        chk("wait_done", 32'(s), 32'h1);
    endtask
    task automatic do_reset();
        @(posedge ref_clk);
        resetn <= 1'b0;
        repeat (4) @(posedge ref_clk);
        chk("rst_prio", 32'(cc_prio), 32'(HPM_CC_PRIO_RST));
        chk("rst_clks", 32'(clks), 32'h8);
        resetn <= 1'b1;
    endtask
    // Hang guard
    always @(posedge ref_clk) begin
        cycles++;
        if (cycles == 30000) begin
            n_mismatch++;
            wrap_up();
        end
    end
    initial begin
        {reg_wr, reg_rd, opcode_valid, watchdog_active, tb_arm} = '0;
        {watchdog_in_halt_option, stab_long_option, resetn} = '0;
        {reg_addr, opcode, reg_wdata, ext_irq, irq_sw_level} = '0;
        void'($urandom(28493));
        do_reset();
        wait_sig(1, 5000);
        wait_sig(2, 4);
        rd(HPM_OFS_CTRL, rv);
        chk("ctrl_rst", rv, 32'h0);
        rd(8'hFC, rv);
        chk("unmapped", rv, 32'h0);
        // Opcodes other than halt keep the CPU running
        for (int i = 0; i < 4; i++) begin
            opcode = (i == 0) ? 8'h8F : 8'($urandom);
            if (opcode == HPM_HALT_OPCODE) opcode = 8'h0E;
            exec(opcode);
            chk("no_halt", 32'(cpu_clk_en), 32'h1);
        end
        // Active-halt with watchdog running, then timebase wake
        @(posedge ref_clk);
        watchdog_active <= 1'b1;
        lvl = 2'($urandom);
        irq_sw_level <= lvl;
        wr(HPM_OFS_CTRL, 32'h1);
        exec(HPM_HALT_OPCODE);
        chk("act_wdg", 32'(watchdog_reset_req), 32'h0);
        chk("act_clks", 32'(clks), 32'h9);
        chk("act_prio", 32'(cc_prio), 32'(HPM_CC_PRIO_HALT));
        @(posedge ref_clk);
        ext_irq <= 4'h1;
        repeat (4) @(negedge ref_clk);
        chk("act_ext", 32'(clks), 32'h9);
        @(posedge ref_clk);
        tb_arm <= 1'b1;
        wait_sig(3, 100);
        @(negedge ref_clk);
        chk("tb_serv", 32'(irq_service), 32'h1);
        chk("tb_push", 32'({cc_push, irq_from_ext}), 32'h2);
        chk("tb_lvl", 32'(cc_prio), 32'(lvl));
        // Clearing the enable inside the guard delay drops to the stabilization state
        @(posedge ref_clk);
        tb_arm <= 1'b0;
        ext_irq <= 4'h0;
        wr(HPM_OFS_CTRL, 32'h0);
        rd(HPM_OFS_STATUS, rv);
        chk("guard_st", rv & 32'h3, 32'h3);
        chk("guard_cpu", 32'(cpu_clk_en), 32'h0);
        wait_sig(2, 300);
        chk("guard_svc", 32'(irq_service), 32'h0);
        chk("pop_prio", 32'(cc_prio), 32'(HPM_CC_PRIO_HALT));
        exec(HPM_HALT_OPCODE);
        chk("wdg_req", 32'(watchdog_reset_req), 32'h1);
        chk("wdg_run", 32'(cpu_clk_en), 32'h1);
        // Full halt, masked source, then wake after each delay option
        for (int opt = 0; opt < 2; opt++) begin
            @(posedge ref_clk);
            watchdog_in_halt_option <= 1'b1;
            stab_long_option <= 1'(opt);
            lvl = 2'($urandom);
            irq_sw_level <= lvl;
            exec(HPM_HALT_OPCODE);
            chk("full_wdg", 32'(watchdog_reset_req), 32'h0);
            chk("full_clks", 32'(clks), 32'h0);
            chk("full_prio", 32'(cc_prio), 32'(HPM_CC_PRIO_HALT));
            @(posedge ref_clk);
            ext_irq <= 4'h8;
            repeat (4) @(negedge ref_clk);
            chk("masked", 32'(osc_en), 32'h0);
            @(posedge ref_clk);
            ext_irq <= 4'h9;
            repeat (2) @(negedge ref_clk);
            chk("osc_on", 32'(clks), 32'h9);
            wait_sig(0, 5000);
            chk("stab_len", n, opt ? HPM_STAB_LONG_CYC
                                   : HPM_STAB_SHORT_CYC);
            chk("ext_src", 32'(irq_from_ext), 32'h1);
            chk("ext_lvl", 32'(cc_prio), 32'(lvl));
            @(posedge ref_clk);
            ext_irq <= 4'h0;
        end
        // A wake source already pending at entry leaves at once
        @(posedge ref_clk);
        ext_irq <= 4'h2;
        exec(HPM_HALT_OPCODE);
        @(negedge ref_clk);
        chk("pend_wake", 32'(osc_en), 32'h1);
        wait_sig(0, 5000);
        @(posedge ref_clk);
        ext_irq <= 4'h0;
        // Sticky status, enable and clear
        rd(HPM_OFS_IRQ_ST, rv);
        chk("ev_all", rv, 32'hF);
        chk("irq_off", 32'(irq), 32'h0);
        wr(HPM_OFS_IRQ_EN, 32'h4);
        @(negedge ref_clk);
        chk("irq_on", 32'(irq), 32'h1);
        wr(HPM_OFS_IRQ_CLR, 32'h4);
        @(negedge ref_clk);
        chk("irq_clr", 32'(irq), 32'h0);
        wr(HPM_OFS_IRQ_ST, 32'h0);
        rd(HPM_OFS_IRQ_ST, rv);
        chk("ev_left", rv, 32'hB);
        rd(HPM_OFS_IRQ_CLR, rv);
        chk("clr_rd", rv, 32'h0);
        // Reset out of active-halt waits the full delay
        wr(HPM_OFS_CTRL, 32'h1);
        exec(HPM_HALT_OPCODE);
        chk("act2", 32'(clks), 32'h9);
        do_reset();
        wait_sig(1, 5000);
        chk("rst_dly", 32'(n >= HPM_STAB_LONG_CYC), 32'h1);
        rd(HPM_OFS_IRQ_EN, rv);
        chk("en_rst", rv, 32'h0);
        wrap_up();
    end
endmodule
`default_nettype wire
